/* rtl/ssio_pkg.sv */
package ssio_pkg;

  // clock and time base: one enable pulse per microsecond
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned TICK_HZ = 1_000_000;
  localparam int unsigned TICK_CYC = CLK_HZ / TICK_HZ;
  localparam int unsigned TICKS_PER_MS = TICK_HZ / 1000;

  // power-on initialization, 1.5 s
  localparam int unsigned INIT_MS = 1500;
  localparam int unsigned INIT_TICKS = INIT_MS * TICKS_PER_MS;

  // ordinary sequence input response, 5 ms; filter leaves margin for sync and tick phase
  localparam int unsigned SEQ_RESP_MS = 5;
  localparam int unsigned SEQ_RESP_TICKS = SEQ_RESP_MS * TICKS_PER_MS;
  localparam int unsigned SEQ_FILT_TICKS = SEQ_RESP_TICKS * 4 / 5;

  // deviation-clear response, 1 ms
  localparam int unsigned DCLR_RESP_MS = 1;
  localparam int unsigned DCLR_RESP_TICKS = DCLR_RESP_MS * TICKS_PER_MS;
  localparam int unsigned DCLR_FILT_TICKS = DCLR_RESP_TICKS * 4 / 5;

  // alarm output and alarm reset delay, 5 ms
  localparam int unsigned ALM_DLY_MS = 5;
  localparam int unsigned ALM_DLY_TICKS = ALM_DLY_MS * TICKS_PER_MS;

  // ordinary sequence input lanes
  localparam int unsigned NSEQ = 4;
  localparam int unsigned SEQ_RUN = 0;
  localparam int unsigned SEQ_MODE = 1;
  localparam int unsigned SEQ_ARST = 2;
  localparam int unsigned SEQ_CLIM = 3;

  // register byte offsets
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_DEV_LIMIT = 12'h004;
  localparam logic [11:0] REG_MAX_SPD = 12'h008;
  localparam logic [11:0] REG_CUR_LVL = 12'h00c;
  localparam logic [11:0] REG_STATUS = 12'h010;
  localparam logic [11:0] REG_DEVIATION = 12'h014;
  localparam logic [11:0] REG_ORIGIN = 12'h018;

  // control bits
  localparam int unsigned CTRL_FAULT_BIT = 0;
  localparam int unsigned CTRL_ARST_BIT = 1;

  // status bits
  localparam int unsigned ST_INIT_BIT = 0;
  localparam int unsigned ST_ALM_OK_BIT = 1;
  localparam int unsigned ST_RDY_BIT = 2;
  localparam int unsigned ST_MODE_BIT = 3;
  localparam int unsigned ST_ZERO_BIT = 4;
  localparam int unsigned ST_CLIM_BIT = 5;
  localparam int unsigned ST_ALM_LSB = 6;

  // reset values, and the fixed zero-speed threshold
  localparam logic [31:0] DEV_LIMIT_RST = 32'h001e_8480;
  localparam logic [15:0] MAX_SPD_RST = 16'h0fff;
  localparam logic [15:0] CUR_LVL_RST = 16'h0800;
  localparam logic [15:0] ZERO_SPD_LVL = 16'h0010;

  typedef enum logic [0:0] {
    MODE_POS = 1'b0,
    MODE_TRQ = 1'b1
  } ssio_mode_e;

  typedef enum logic [1:0] {
    ALM_IDLE = 2'b00,
    ALM_DET = 2'b01,
    ALM_ON = 2'b10,
    ALM_RST = 2'b11
  } ssio_alm_e;

  function automatic logic [15:0] abs16(input logic [15:0] v);
    abs16 = v[15] ? 16'(-v) : v;
  endfunction

  function automatic logic [31:0] abs32(input logic [31:0] v);
    abs32 = v[31] ? 32'(-v) : v;
  endfunction

endpackage

/* rtl/ssio_in_filter.sv */
`timescale 1ns/1ps
// two-flop synchroniser followed by a stability filter on the microsecond tick
module ssio_in_filter #(
  parameter int unsigned STABLE_TICKS = 4000,
  parameter int unsigned CW = 13
) (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic tick, // one-cycle microsecond enable
  input wire logic pin_in, // raw pin level
  output logic level_out // recognised level
);

  logic sync_a_ff;
  logic sync_b_ff;
  logic lvl_ff;
  logic [CW-1:0] cnt_ff;

  // metastability guard; only sync_b_ff is looked at
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_a_ff <= 1'b0;
      sync_b_ff <= 1'b0;
    end
    else
    begin
      sync_a_ff <= pin_in;
      sync_b_ff <= sync_a_ff;
    end
  end

  // a glitch shorter than the stable time restarts the count and is dropped
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_ff <= '0;
      lvl_ff <= 1'b0;
    end
    else if (sync_b_ff == lvl_ff)
      cnt_ff <= '0;
    else if (tick)
    begin
      if (cnt_ff == CW'(STABLE_TICKS - 1))
      begin
        lvl_ff <= sync_b_ff;
        cnt_ff <= '0;
      end
      else
        cnt_ff <= cnt_ff + 1'b1;
    end
  end

  assign level_out = lvl_ff;

  a_filt_change: assert property (@(posedge pclk) disable iff (!presetn)
    (lvl_ff != $past(lvl_ff)) |-> ($past(tick) && $past(cnt_ff) == CW'(STABLE_TICKS - 1)))
    else $error("recognised level moved before the stable time");

  a_filt_glitch: assert property (@(posedge pclk) disable iff (!presetn)
    (sync_b_ff == lvl_ff) |=> (cnt_ff == '0))
    else $error("stability count not restarted on agreement");

endmodule

/* rtl/ssio_top.sv */
`timescale 1ns/1ps
// Functional notes
// - initialization completes about 1.5 s after a supply is switched on.
// - alarm-detection output turns ON (no alarm) when initialization completes.
// - servo-ready output asserts once servo-on is accepted.
// - ordinary sequence inputs are recognised within 5 ms.
// - deviation-clear recognised within 1 ms; host holds it at least 1 ms.
// - control-mode transition completes within 5 ms of the mode input change.
// - alarm-detection output updates about 5 ms after an alarm arises.
// - an active alarm clears about 5 ms after alarm-reset is asserted; the alarm-reset pin first passes its 4 ms input filter.
// - on torque-to-position switch, origin captured before switch is held.
// - maximum-speed setting is ignored in position control.
// - in torque control, torque is reduced once speed reaches maximum.
// - deviation above the deviation limit raises an alarm in position control.
module ssio_top #(
  parameter int unsigned INIT_TICKS = ssio_pkg::INIT_TICKS,
  parameter int unsigned SEQ_FILT_TICKS = ssio_pkg::SEQ_FILT_TICKS,
  parameter int unsigned DCLR_FILT_TICKS = ssio_pkg::DCLR_FILT_TICKS,
  parameter int unsigned ALM_DLY_TICKS = ssio_pkg::ALM_DLY_TICKS
) (
  input wire logic pclk, // 40 MHz system clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic motor_pwr_in, // motor supply present pin
  input wire logic ctrl_pwr_in, // control supply present pin
  input wire logic run_in, // servo-on command pin
  input wire logic dev_clr_in, // deviation-clear pin
  input wire logic mode_sel_in, // mode select pin, 1 = torque
  input wire logic alm_rst_in, // alarm-reset pin
  input wire logic cur_lim_in, // current-limit request pin
  input wire logic step_in, // pulse-string step pin
  input wire logic dir_in, // pulse-string direction pin
  input wire logic fault_in, // internal fault from power stage
  input wire logic [31:0] pos_fb, // encoder position
  input wire logic [15:0] speed_fb, // signed motor speed
  input wire logic [15:0] trq_fb, // signed actual torque
  input wire logic [15:0] trq_cmd, // signed sampled analog torque command
  output logic alm_ok_out, // break-contact alarm output, 1 = no alarm
  output logic srv_rdy_out, // servo ready
  output logic zero_spd_out, // zero speed detected
  output logic cur_lim_det_out, // current limit reached
  output logic mode_act_out, // active mode, 1 = torque
  output logic [15:0] trq_out, // torque command to current loop
  output logic [31:0] pos_tgt_out, // position target
  output logic [31:0] dev_out // position deviation
);

  logic [5:0] div_ff;
  logic tick_ff;
  logic mpwr_a_ff, mpwr_b_ff, cpwr_a_ff, cpwr_b_ff;
  logic step_a_ff, step_b_ff, step_c_ff, dir_a_ff, dir_b_ff;
  logic [ssio_pkg::NSEQ-1:0] seq_pin;
  logic [ssio_pkg::NSEQ-1:0] seq_rec;
  logic dclr_rec;
  logic arst_d_ff;
  logic [23:0] init_cnt_ff;
  logic init_done_ff;
  ssio_pkg::ssio_alm_e alm_st_ff;
  logic [15:0] alm_cnt_ff;
  logic alm_ok_ff, srv_rdy_ff, zero_ff, clim_ff;
  ssio_pkg::ssio_mode_e mode_act_ff;
  ssio_pkg::ssio_mode_e mode_req;
  logic [31:0] cmd_pos_ff, origin_ff, dev_ff;
  logic [15:0] trq_out_ff;
  logic dev_over, spd_over, fault_now, arst_req;
  logic ctrl_fault_ff, sw_arst_ff;
  logic [31:0] dev_limit_ff;
  logic [15:0] max_spd_ff, cur_lvl_ff;
  logic [31:0] prdata_ff, rd_mux;
  logic addr_hit, wr_en;

  // microsecond enable; every slow timer counts these pulses
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_ff <= '0;
      tick_ff <= 1'b0;
    end
    else
    begin
      tick_ff <= (div_ff == 6'(ssio_pkg::TICK_CYC - 1));
      div_ff <= (div_ff == 6'(ssio_pkg::TICK_CYC - 1)) ? '0 : div_ff + 1'b1;
    end
  end

  // supply and pulse pins are asynchronous; second flop is the first one logic reads
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {mpwr_a_ff, mpwr_b_ff, cpwr_a_ff, cpwr_b_ff} <= 4'h0;
      {step_a_ff, step_b_ff, step_c_ff, dir_a_ff, dir_b_ff} <= 5'h00;
    end
    else
    begin
      {mpwr_b_ff, mpwr_a_ff} <= {mpwr_a_ff, motor_pwr_in};
      {cpwr_b_ff, cpwr_a_ff} <= {cpwr_a_ff, ctrl_pwr_in};
      {step_c_ff, step_b_ff, step_a_ff} <= {step_b_ff, step_a_ff, step_in};
      {dir_b_ff, dir_a_ff} <= {dir_a_ff, dir_in};
    end
  end

  // ordinary sequence inputs share one filter length
  assign seq_pin[ssio_pkg::SEQ_RUN] = run_in;
  assign seq_pin[ssio_pkg::SEQ_MODE] = mode_sel_in;
  assign seq_pin[ssio_pkg::SEQ_ARST] = alm_rst_in;
  assign seq_pin[ssio_pkg::SEQ_CLIM] = cur_lim_in;

  for (genvar gi = 0; gi < ssio_pkg::NSEQ; gi++)
  begin : g_seq
    ssio_in_filter #(.STABLE_TICKS(SEQ_FILT_TICKS), .CW(16)) u_filt (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick_ff),
      .pin_in(seq_pin[gi]),
      .level_out(seq_rec[gi])
    );
  end

  // deviation clear uses the short filter
  ssio_in_filter #(.STABLE_TICKS(DCLR_FILT_TICKS), .CW(16)) u_dclr (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick_ff),
    .pin_in(dev_clr_in),
    .level_out(dclr_rec)
  );

  // initialization timer restarts whenever both supplies are gone
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      init_cnt_ff <= '0;
      init_done_ff <= 1'b0;
    end
    else if (!(mpwr_b_ff || cpwr_b_ff))
    begin
      init_cnt_ff <= '0;
      init_done_ff <= 1'b0;
    end
    else if (!init_done_ff && tick_ff)
    begin
      if (init_cnt_ff == 24'(INIT_TICKS - 1))
        init_done_ff <= 1'b1;
      else
        init_cnt_ff <= init_cnt_ff + 1'b1;
    end
  end

  // alarm sources and reset requests (reset is edge-triggered so a held pin cannot loop)
  assign fault_now = fault_in || dev_over || ctrl_fault_ff;
  assign arst_req = (seq_rec[ssio_pkg::SEQ_ARST] && !arst_d_ff) || sw_arst_ff;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      arst_d_ff <= 1'b0;
    else
      arst_d_ff <= seq_rec[ssio_pkg::SEQ_ARST];
  end

  // alarm sequencer: detection delay, latched alarm, reset delay
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      alm_st_ff <= ssio_pkg::ALM_IDLE;
      alm_cnt_ff <= '0;
    end
    else
    begin
      case (alm_st_ff)
        ssio_pkg::ALM_IDLE:
        begin
          alm_cnt_ff <= '0;
          if (fault_now)
            alm_st_ff <= ssio_pkg::ALM_DET;
        end
        ssio_pkg::ALM_DET:
        begin
          if (tick_ff)
          begin
            if (alm_cnt_ff == 16'(ALM_DLY_TICKS - 1))
            begin
              alm_st_ff <= ssio_pkg::ALM_ON;
              alm_cnt_ff <= '0;
            end
            else
              alm_cnt_ff <= alm_cnt_ff + 1'b1;
          end
        end
        ssio_pkg::ALM_ON:
        begin
          alm_cnt_ff <= '0;
          if (arst_req)
            alm_st_ff <= ssio_pkg::ALM_RST;
        end
        ssio_pkg::ALM_RST:
        begin
          if (tick_ff)
          begin
            if (alm_cnt_ff == 16'(ALM_DLY_TICKS - 1))
            begin
              // a fault still present re-latches instead of clearing
              alm_st_ff <= fault_now ? ssio_pkg::ALM_ON : ssio_pkg::ALM_IDLE;
              alm_cnt_ff <= '0;
            end
            else
              alm_cnt_ff <= alm_cnt_ff + 1'b1;
          end
        end
        default:
        begin
          alm_st_ff <= ssio_pkg::ALM_IDLE;
          alm_cnt_ff <= '0;
        end
      endcase
    end
  end

  // break-contact output: ON only after init and while no alarm is shown
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      alm_ok_ff <= 1'b0;
      srv_rdy_ff <= 1'b0;
    end
    else
    begin
      alm_ok_ff <= init_done_ff && (alm_st_ff != ssio_pkg::ALM_ON) && (alm_st_ff != ssio_pkg::ALM_RST);
      srv_rdy_ff <= seq_rec[ssio_pkg::SEQ_RUN] && alm_ok_ff && mpwr_b_ff;
    end
  end

  // mode follows the recognised select one cycle later, well inside the 5 ms budget
  assign mode_req = seq_rec[ssio_pkg::SEQ_MODE] ? ssio_pkg::MODE_TRQ : ssio_pkg::MODE_POS;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode_act_ff <= ssio_pkg::MODE_POS;
    else
      mode_act_ff <= mode_req;
  end

  // position command: pulses in position mode, tracks encoder in torque mode
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmd_pos_ff <= '0;
      origin_ff <= '0;
    end
    else if (mode_act_ff == ssio_pkg::MODE_TRQ)
    begin
      if (mode_req == ssio_pkg::MODE_TRQ)
      begin
        origin_ff <= pos_fb;
        cmd_pos_ff <= pos_fb;
      end
      else
        cmd_pos_ff <= origin_ff;
    end
    else if (dclr_rec)
      cmd_pos_ff <= pos_fb;
    else if (step_b_ff && !step_c_ff)
      cmd_pos_ff <= dir_b_ff ? cmd_pos_ff - 1'b1 : cmd_pos_ff + 1'b1;
  end

  // deviation register and limit check
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dev_ff <= '0;
    else
      dev_ff <= cmd_pos_ff - pos_fb;
  end

  assign dev_over = (mode_act_ff == ssio_pkg::MODE_POS) && (ssio_pkg::abs32(dev_ff) > dev_limit_ff);

  // speed limit only applies to torque control
  assign spd_over = (mode_act_ff == ssio_pkg::MODE_TRQ) && (ssio_pkg::abs16(speed_fb) >= max_spd_ff);

  // torque output halves at the speed limit rather than cutting off, to avoid chatter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      trq_out_ff <= '0;
    else if (!srv_rdy_ff || mode_act_ff != ssio_pkg::MODE_TRQ)
      trq_out_ff <= '0;
    else if (spd_over)
      trq_out_ff <= 16'($signed(trq_cmd) >>> 1);
    else
      trq_out_ff <= trq_cmd;
  end

  // hit-and-stop indicators for the host
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      zero_ff <= 1'b0;
      clim_ff <= 1'b0;
    end
    else
    begin
      zero_ff <= ssio_pkg::abs16(speed_fb) <= ssio_pkg::ZERO_SPD_LVL;
      clim_ff <= seq_rec[ssio_pkg::SEQ_CLIM] && (ssio_pkg::abs16(trq_fb) >= cur_lvl_ff);
    end
  end

  // apb decode; zero wait states
  always_comb
  begin
    addr_hit = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      ssio_pkg::REG_CTRL:
        rd_mux[ssio_pkg::CTRL_FAULT_BIT] = ctrl_fault_ff;
      ssio_pkg::REG_DEV_LIMIT:
        rd_mux = dev_limit_ff;
      ssio_pkg::REG_MAX_SPD:
        rd_mux[15:0] = max_spd_ff;
      ssio_pkg::REG_CUR_LVL:
        rd_mux[15:0] = cur_lvl_ff;
      ssio_pkg::REG_STATUS:
      begin
        rd_mux[ssio_pkg::ST_INIT_BIT] = init_done_ff;
        rd_mux[ssio_pkg::ST_ALM_OK_BIT] = alm_ok_ff;
        rd_mux[ssio_pkg::ST_RDY_BIT] = srv_rdy_ff;
        rd_mux[ssio_pkg::ST_MODE_BIT] = mode_act_ff;
        rd_mux[ssio_pkg::ST_ZERO_BIT] = zero_ff;
        rd_mux[ssio_pkg::ST_CLIM_BIT] = clim_ff;
        rd_mux[ssio_pkg::ST_ALM_LSB +: 2] = alm_st_ff;
      end
      ssio_pkg::REG_DEVIATION:
        rd_mux = dev_ff;
      ssio_pkg::REG_ORIGIN:
        rd_mux = origin_ff;
      default:
        addr_hit = 1'b0;
    endcase
  end

  assign wr_en = psel && penable && pwrite && addr_hit;

  // writable registers; alarm-reset bit is a self-clearing pulse
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_fault_ff <= 1'b0;
      sw_arst_ff <= 1'b0;
      dev_limit_ff <= ssio_pkg::DEV_LIMIT_RST;
      max_spd_ff <= ssio_pkg::MAX_SPD_RST;
      cur_lvl_ff <= ssio_pkg::CUR_LVL_RST;
    end
    else
    begin
      sw_arst_ff <= wr_en && (paddr == ssio_pkg::REG_CTRL) && pwdata[ssio_pkg::CTRL_ARST_BIT];
      if (wr_en && paddr == ssio_pkg::REG_CTRL)
        ctrl_fault_ff <= pwdata[ssio_pkg::CTRL_FAULT_BIT];
      if (wr_en && paddr == ssio_pkg::REG_DEV_LIMIT)
        dev_limit_ff <= pwdata;
      if (wr_en && paddr == ssio_pkg::REG_MAX_SPD)
        max_spd_ff <= pwdata[15:0];
      if (wr_en && paddr == ssio_pkg::REG_CUR_LVL)
        cur_lvl_ff <= pwdata[15:0];
    end
  end

  // read data captured in the setup cycle so it is a flop in the access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_ff <= '0;
    else if (psel && !penable && !pwrite)
      prdata_ff <= rd_mux;
  end

  assign prdata = prdata_ff;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_hit;
  assign alm_ok_out = alm_ok_ff;
  assign srv_rdy_out = srv_rdy_ff;
  assign zero_spd_out = zero_ff;
  assign cur_lim_det_out = clim_ff;
  assign mode_act_out = mode_act_ff;
  assign trq_out = trq_out_ff;
  assign pos_tgt_out = cmd_pos_ff;
  assign dev_out = dev_ff;

  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_trq_to_pos;
    (mode_act_ff == ssio_pkg::MODE_TRQ) ##1 (mode_act_ff == ssio_pkg::MODE_POS);
  endsequence

  sequence s_alarm_cleared;
    (alm_st_ff == ssio_pkg::ALM_RST) ##1 (alm_st_ff == ssio_pkg::ALM_IDLE);
  endsequence

  a_init_time: assert property ($rose(init_done_ff) |->
    ($past(tick_ff) && $past(init_cnt_ff) == 24'(INIT_TICKS - 1)))
    else $error("init done before 1.5 s count");
  a_alm_init: assert property (!init_done_ff |=> !alm_ok_ff)
    else $error("alarm output ON before init");
  a_ready_cause: assert property (srv_rdy_ff |->
    $past(seq_rec[ssio_pkg::SEQ_RUN] && alm_ok_ff && mpwr_b_ff))
    else $error("ready without servo-on and healthy alarm output");
  a_mode_follow: assert property ((mode_req != mode_act_ff) |=> (mode_act_ff == $past(mode_req)))
    else $error("mode did not follow select");
  a_alm_delay: assert property (($past(alm_st_ff) == ssio_pkg::ALM_DET && alm_st_ff == ssio_pkg::ALM_ON) |->
    ($past(alm_cnt_ff) == 16'(ALM_DLY_TICKS - 1)))
    else $error("alarm shown before 5 ms");
  a_alm_reset: assert property (s_alarm_cleared |->
    ($past(alm_cnt_ff) == 16'(ALM_DLY_TICKS - 1) && $past(tick_ff)))
    else $error("alarm cleared before 5 ms");
  a_origin_hold: assert property (s_trq_to_pos |-> (cmd_pos_ff == origin_ff && origin_ff == $past(origin_ff)))
    else $error("origin lost on switch to position");
  a_spd_limit: assert property ((mode_act_ff == ssio_pkg::MODE_TRQ && srv_rdy_ff && spd_over) |=>
    (trq_out_ff == 16'($signed($past(trq_cmd)) >>> 1)))
    else $error("torque not reduced at speed limit");
  a_pos_nolim: assert property ((mode_act_ff == ssio_pkg::MODE_POS && !dclr_rec && step_b_ff && !step_c_ff) |=>
    (cmd_pos_ff == ($past(dir_b_ff) ? $past(cmd_pos_ff) - 32'h0000_0001 : $past(cmd_pos_ff) + 32'h0000_0001)))
    else $error("pulse not followed in position mode");
  a_dev_alarm: assert property ((dev_over && alm_st_ff == ssio_pkg::ALM_IDLE) |=>
    (alm_st_ff == ssio_pkg::ALM_DET))
    else $error("deviation over limit not alarmed");

endmodule

/* tb/ssio_host.sv */
`timescale 1ns/1ps
// host controller model: servo-on sequencing and hit-and-stop homing pulses
module ssio_host #(
  parameter int RUN_WAIT = 400
) (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic alm_ok_out, // no-alarm output of the amplifier
  input wire logic motor_pwr_in, // motor supply present
  input wire logic zero_spd_out, // zero speed detected
  input wire logic cur_lim_det_out, // current limit detected
  input wire logic home, // bench request to run origin return
  output logic run_in, // servo-on command
  output logic step_in, // pulse-string step
  output logic cur_lim_in, // current-limit request
  output int steps // rising steps issued so far
);
  int wait_c;
  int ph;
  // servo-on only after a settle time with no alarm and motor power; dropped on alarm
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      wait_c <= 0;
      run_in <= 1'b0;
    end
    else if (!alm_ok_out || !motor_pwr_in)
    begin
      wait_c <= 0;
      run_in <= 1'b0;
    end
    else if (wait_c < RUN_WAIT)
      wait_c <= wait_c + 1;
    else
      run_in <= 1'b1;
  // slow pulses and current limit start together; pulses stop on zero speed and limit reached, current limit follows home
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ph <= 0;
      step_in <= 1'b0;
      steps <= 0;
      cur_lim_in <= 1'b0;
    end
    else
    begin
      cur_lim_in <= home;
      if (home && !(zero_spd_out && cur_lim_det_out))
      begin
        ph <= ph + 1;
        step_in <= (ph % 8) < 4;
        if (ph % 8 == 0)
          steps <= steps + 1;
      end
      else
        step_in <= 1'b0;
    end
endmodule

/* tb/tb.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin failures++; $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
`define WT(c) begin n = 0; while (!(c) && n < 5000) begin @(posedge pclk); n++; end end
module tb;
  localparam int SF = 4, DF = 2, AD = 5, IT = 50, T = 40;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, motor_pwr_in = 0, dev_clr_in = 0;
  logic mode_sel_in = 0, alm_rst_in = 0, home = 0, err, pready, pslverr, alm_ok_out, srv_rdy_out;
  logic zero_spd_out, cur_lim_det_out, mode_act_out, run_in, step_in, cur_lim_in, ctrl_pwr_in = 0, fault_in = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, pos_fb = 32'h0000_0000, rd, q, prdata, pos_tgt_out, dev_out;
  logic [15:0] speed_fb = 16'h0000, trq_fb = 16'h0000, trq_cmd = 16'h0000, trq_out, exp_t;
  int failures = 0, comparisons = 0, cyc = 0, n, steps;
  always #12.5 pclk = ~pclk;
  ssio_top #(.INIT_TICKS(IT), .SEQ_FILT_TICKS(SF), .DCLR_FILT_TICKS(DF), .ALM_DLY_TICKS(AD)) ssio_top_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .motor_pwr_in,
    .ctrl_pwr_in, .run_in, .dev_clr_in, .mode_sel_in, .alm_rst_in, .cur_lim_in, .step_in, .dir_in(1'b0),
    .fault_in, .pos_fb, .speed_fb, .trq_fb, .trq_cmd, .alm_ok_out, .srv_rdy_out, .zero_spd_out,
    .cur_lim_det_out, .mode_act_out, .trq_out, .pos_tgt_out, .dev_out);
  ssio_host #(.RUN_WAIT(400)) ssio_host_inst (.pclk, .presetn, .alm_ok_out, .motor_pwr_in, .zero_spd_out,
    .cur_lim_det_out, .home, .run_in, .step_in, .cur_lim_in, .steps);
  task tally_and_finish;
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // one apb transfer; pready is waited for, never assumed
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // hang guard
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      failures++;
      tally_and_finish;
    end
  end
  initial
  begin
    void'($urandom(80325));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    ctrl_pwr_in <= 1'b1;
    `WT(alm_ok_out) `CHK(n >= (IT - 1) * T && n <= (IT + 1) * T + 8, 1'b1)
    // control supply alone: servo-on must wait for motor power
    repeat (500) @(posedge pclk);
    `CHK(srv_rdy_out, 1'b0)
    motor_pwr_in <= 1'b1;
    `WT(srv_rdy_out) `CHK(n >= 400, 1'b1)
    apb(0, 12'h004, 0); `CHK(rd, ssio_pkg::DEV_LIMIT_RST)
    apb(1, 12'h008, 32'h0000_0100);
    apb(0, 12'h008, 0); `CHK(rd, 32'h0000_0100)
    apb(0, 12'h020, 0); `CHK(err, 1'b1)
    apb(1, 12'h00c, 32'h0000_7000);
    apb(0, 12'h00c, 0); `CHK(rd, 32'h0000_7000)
    // clear deviation, then home against the stop at a speed above the limit
    // small offset keeps the deviation under the limit, so no alarm starts here
    pos_fb <= 32'($urandom_range(4000, 1));
    speed_fb <= 16'h0200;
    dev_clr_in <= 1'b1;
    @(posedge pclk);
    `WT(pos_tgt_out === pos_fb) `CHK(n <= (DF + 1) * T + 8, 1'b1)
    repeat (T) @(posedge pclk);
    dev_clr_in <= 1'b0;
    repeat ((DF + 2) * T) @(posedge pclk);
    home <= 1'b1;
    repeat (600) @(posedge pclk);
    speed_fb <= 16'h0000;
    trq_fb <= 16'h7fff;
    `WT(cur_lim_det_out && zero_spd_out) `CHK(n < 5000, 1'b1)
    repeat (20) @(posedge pclk);
    `CHK(pos_tgt_out, pos_fb + steps)
    `CHK(dev_out, 32'(steps))
    home <= 1'b0;
    dev_clr_in <= 1'b1;
    repeat ((SF + 1) * T) @(posedge pclk);
    `CHK(dev_out, 32'h0000_0000)
    dev_clr_in <= 1'b0;
    // a pulse shorter than the filter is dropped
    mode_sel_in <= 1'b1;
    repeat ((SF - 2) * T) @(posedge pclk);
    mode_sel_in <= 1'b0;
    repeat ((SF + 2) * T) @(posedge pclk);
    `CHK(mode_act_out, 1'b0)
    mode_sel_in <= 1'b1;
    `WT(mode_act_out) `CHK(n >= (SF - 1) * T && n <= (SF + 1) * T + 6, 1'b1)
    repeat (2 * T) @(posedge pclk);
    for (int i = 0; i < 4; i++)
    begin
      trq_cmd <= 16'($urandom);
      speed_fb <= i[0] ? (i[1] ? 16'hff00 : 16'h0100) : 16'h0000;
      repeat (4) @(posedge pclk);
      exp_t = i[0] ? 16'($signed(trq_cmd) >>> 1) : trq_cmd;
      `CHK(trq_out, exp_t)
    end
    q = pos_fb;
    mode_sel_in <= 1'b0;
    `WT(!mode_act_out) `CHK(mode_act_out, 1'b0)
    pos_fb <= pos_fb + 32'd50;
    repeat (4) @(posedge pclk);
    `CHK(pos_tgt_out, q)
    apb(0, 12'h018, 0); `CHK(rd, q)
    `CHK(trq_out, 16'h0000)
    apb(1, 12'h000, 32'h0000_0001);
    `WT(!alm_ok_out) `CHK(n >= (AD - 1) * T && n <= (AD + 1) * T + 6, 1'b1)
    `WT(!srv_rdy_out) `CHK(n <= 4, 1'b1)
    apb(1, 12'h000, 32'h0000_0000);
    alm_rst_in <= 1'b1;
    `WT(alm_ok_out) `CHK(n >= (SF + AD - 2) * T && n <= (SF + AD + 2) * T + 8, 1'b1)
    alm_rst_in <= 1'b0;
    `WT(srv_rdy_out) `CHK(srv_rdy_out, 1'b1)
    // limit below the 50-count deviation left by the mode switch raises an alarm
    apb(1, 12'h004, 32'h0000_0010);
    `WT(!alm_ok_out) `CHK(n >= (AD - 1) * T && n <= (AD + 1) * T + 6, 1'b1)
    // a reset while a fault persists must re-latch the alarm
    fault_in <= 1'b1;
    apb(1, 12'h000, 32'h0000_0002);
    repeat ((AD + 2) * T) @(posedge pclk);
    `CHK(alm_ok_out, 1'b0)
    fault_in <= 1'b0;
    dev_clr_in <= 1'b1;
    repeat ((DF + 2) * T) @(posedge pclk);
    `CHK(dev_out, 32'h0000_0000)
    apb(1, 12'h000, 32'h0000_0002);
    `WT(alm_ok_out) `CHK(n >= (AD - 1) * T && n <= (AD + 1) * T + 6, 1'b1)
    tally_and_finish;
  end
endmodule
